/* File: supervisor_pkg.sv */
// Purpose: shared codes, reset values and timing for the input supervisor
// Assumes: limits and gain use the 5-bit exponent / 11-bit mantissa word
// Notes:   l11_q16 turns such a word into a signed value with 16 fraction bits
package supervisor_pkg;
   typedef logic [15:0] word_t;
   typedef logic [7:0]  code_t;
   typedef logic [47:0] acc_t;

   localparam code_t CMD_TURN_ON  = 8'h35;
   localparam code_t CMD_TURN_OFF = 8'h36;
   localparam code_t CMD_OV_FAULT = 8'h55;
   localparam code_t CMD_OV_WARN  = 8'h57;
   localparam code_t CMD_UV_WARN  = 8'h58;
   localparam code_t CMD_UV_FAULT = 8'h59;
   localparam code_t CMD_REPORT   = 8'hC0;
   localparam code_t CMD_CONFIG   = 8'hC1;
   localparam code_t CMD_TEMPCO   = 8'hC3;
   localparam code_t CMD_CLEAR    = 8'hCC;
   localparam code_t CMD_GAIN     = 8'hE8;

   // limit storage index order: on, off, ov fault, ov warn, uv warn, uv fault
   localparam logic [2:0] LIM_ON = 3'h0, LIM_OFF = 3'h1, LIM_OVF = 3'h2;
   localparam logic [2:0] LIM_OVW = 3'h3, LIM_UVW = 3'h4, LIM_UVF = 3'h5;
   localparam logic [5:0][15:0] LIM_RESET =
      {16'h8000, 16'h8000, 16'hD380, 16'hD3C0, 16'hD240, 16'hD280};
   localparam word_t      GAIN_RESET   = 16'hBA00;
   localparam word_t      TEMPCO_RESET = 16'h0000;
   localparam logic       HIGH_DEF_RESET   = 1'b0;
   localparam int         CFG_HIGH_DEF_BIT = 2;
   localparam logic [3:0] REPORT_BYTES = 4'hC;

   localparam int ST_OV_FAULT = 0, ST_OV_WARN = 1, ST_UV_WARN = 2, ST_UV_FAULT = 3;

   localparam int MS_PERIOD_NS  = 1000000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

   localparam int TEMP_REF_C   = 25;
   localparam int PPM_RECIP    = 4295;      // 2^32 / 1e6
   localparam int TCORR_ONE    = 65536;
   localparam int TCORR_MIN    = 16384;     // 0.25
   localparam int TCORR_MAX    = 262144;    // 4.0
   localparam int GAIN_MIN_Q16 = 655;       // 0.01 mohm
   localparam int GAIN_MAX_Q16 = 65536000;  // 1000 mohm
   localparam int MV_PER_V     = 1000;
   localparam int NJ_PER_MJ    = 1000000;
   localparam int NJ_RECIP     = 4294;      // floor(2^32 / 1e6)
   localparam int DIV_STEPS    = 32;

   function automatic logic signed [47:0] l11_q16(input word_t w);
      logic [4:0] sh;
      sh = {~w[15], w[14:11]};
      return 48'(signed'(w[10:0])) <<< sh;
   endfunction : l11_q16
endpackage : supervisor_pkg

/* File: restoring_divider.sv */
// Purpose: unsigned 32 / 32 divider, one quotient bit per clock
// Assumes: den is never zero while start is raised
// Notes:   start is ignored while busy
`timescale 1ns/1ps
`default_nettype none
module restoring_divider (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic [31:0] num,
   input  wire logic [31:0] den,
   output var  logic        busy,
   output var  logic        done,
   output var  logic [31:0] quot
);
   import supervisor_pkg::*;
   typedef struct packed {
      logic [32:0] rem;
      logic [31:0] quo;
      logic [31:0] den;
      logic [5:0]  cnt;
      logic        busy;
      logic        done;
   } div_t;
   div_t r_reg, r_next;
   logic [32:0] sh;

   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      sh = {r_reg.rem[31:0], r_reg.quo[31]};
      if (r_reg.busy) begin
         r_next.quo = {r_reg.quo[30:0], 1'b0};
         if (sh >= {1'b0, r_reg.den}) begin
            r_next.rem = sh - {1'b0, r_reg.den};
            r_next.quo[0] = 1'b1;
         end else begin
            r_next.rem = sh;
         end
         r_next.cnt = r_reg.cnt - 6'h01;
         if (r_reg.cnt == 6'h01) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end
      end else if (start) begin
         r_next.rem  = 33'h0;
         r_next.quo  = num;
         r_next.den  = den;
         r_next.cnt  = 6'(DIV_STEPS);
         r_next.busy = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) r_reg <= '0;
      else r_reg <= r_next;
   end

   assign busy = r_reg.busy;
   assign done = r_reg.done;
   assign quot = r_reg.quo;
endmodule : restoring_divider
`default_nettype wire

/* File: sense_resistance_scaler.sv */
// Purpose: effective sense resistance in mohm with 16 fraction bits
// Assumes: die temperature arrives as signed whole degrees
// Notes:   the stored gain word is untouched; only the value used is limited
`timescale 1ns/1ps
`default_nettype none
module sense_resistance_scaler (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire supervisor_pkg::word_t gain_word,
   input  wire supervisor_pkg::word_t tempco_word,
   input  wire logic signed [15:0]  die_temp_c,
   output var  logic [31:0]         r_q16
);
   import supervisor_pkg::*;
   typedef struct packed {
      logic [31:0] r;
   } scale_t;
   scale_t r_reg, r_next;
   logic signed [47:0] g;
   logic [25:0]        gc;
   logic signed [45:0] prod, t;
   logic [18:0]        tc;
   logic [44:0]        full;

   always_comb begin
      r_next = r_reg;
      g = l11_q16(gain_word);
      if (g < 48'(GAIN_MIN_Q16)) gc = 26'(GAIN_MIN_Q16);
      else if (g > 48'(GAIN_MAX_Q16)) gc = 26'(GAIN_MAX_Q16);
      else gc = g[25:0];
      prod = 46'(signed'(tempco_word)) * 46'(die_temp_c - 16'(TEMP_REF_C))
           * 46'(PPM_RECIP);
      t = 46'(TCORR_ONE) + (prod >>> 16);
      if (t < 46'(TCORR_MIN)) tc = 19'(TCORR_MIN); // clamp 0.25..4
      else if (t > 46'(TCORR_MAX)) tc = 19'(TCORR_MAX);
      else tc = t[18:0];
      full = 45'(gc) * 45'(tc); // tempco applied to gain
      r_next.r = 32'(full >> 16);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) r_reg <= '0;
      else r_reg <= r_next;
   end

   assign r_q16 = r_reg.r;
endmodule : sense_resistance_scaler
`default_nettype wire

/* File: input_energy_supervisor.sv */
// Purpose: input voltage supervision and input energy / time accounting
// Assumes: all inputs come from logic on MCLK; PMBus framing is decoded upstream
// Notes:   energy updates on the millisecond tick together with time
`timescale 1ns/1ps
`default_nettype none
module input_energy_supervisor #(
   parameter int MS_CYCLES = supervisor_pkg::MS_CYCLES
) (
   input  wire logic                  MCLK,
   input  wire logic                  RESETN,
   input  wire logic                  CMD_WR,
   input  wire logic                  CMD_SEND,
   input  wire logic                  CMD_RD,
   input  wire supervisor_pkg::code_t CMD_CODE,
   input  wire supervisor_pkg::word_t CMD_WDATA,
   input  wire logic                  BYTE_RD,
   input  wire logic [3:0]            BYTE_INDEX,
   input  wire logic                  BLK_DONE,
   output var  supervisor_pkg::word_t RD_DATA,
   output var  logic                  RD_VALID,
   input  wire logic                  VIN_VALID,
   input  wire supervisor_pkg::word_t VIN_WORD,
   input  wire logic                  IIN_VALID,
   input  wire logic signed [15:0]    IIN_SENSE_UV,
   input  wire logic signed [15:0]    DIE_TEMP_C,
   input  wire logic                  ADC_BUSY,
   input  wire logic [1:0]            CHAN_REQ,
   input  wire logic                  TRACK_ENABLE,
   input  wire logic [15:0]           TOFF_DELAY_MS,
   output var  logic [1:0]            OUTPUT_ENABLE_PIN,
   output var  logic                  CONVERSION_ALLOWED,
   output var  logic [3:0]            VIN_STATUS,
   output var  logic                  HIGH_DEFINITION
);
   import supervisor_pkg::*;

   typedef struct packed {
      logic [5:0][15:0] lim;
      word_t            gain;
      word_t            tempco;
      logic             high_def;
      acc_t             energy;
      acc_t             time_ms;
      logic [19:0]      res;
      logic [16:0]      ms_cnt;
      acc_t             snap_e;
      acc_t             snap_t;
      logic             frozen;
      word_t            rd_data;
      logic             rd_valid;
      logic             vin_good;
      logic [3:0]       status;
      logic [1:0]       en;
      logic             toff_run;
      logic [15:0]      toff_cnt;
      logic             clr_pend;
      logic [15:0]      vin_mv;
      logic [15:0]      iin_ma;
      logic             iin_neg;
      logic [15:0]      sense_mag;
      logic             sense_neg;
      logic             div_start;
   } state_t;

   state_t             r_reg, r_next;
   logic               div_busy, div_done;
   logic [31:0]        quot, r_q16;
   logic signed [47:0] vin_q;
   logic signed [57:0] mv_full;
   logic               ms_tick, clear_now, dec_now;
   logic [31:0]        p_uw;
   logic [32:0]        x, rem;
   logic [45:0]        qp;
   logic [13:0]        q;
   logic [3:0]         sel;
   logic [95:0]        report;

   // ****************************************************
   // command decoding
   // ****************************************************
   function automatic logic [3:0] lim_sel(input code_t c);
      case (c)
         CMD_TURN_ON:  return {1'b1, LIM_ON};
         CMD_TURN_OFF: return {1'b1, LIM_OFF};
         CMD_OV_FAULT: return {1'b1, LIM_OVF};
         CMD_OV_WARN:  return {1'b1, LIM_OVW};
         CMD_UV_WARN:  return {1'b1, LIM_UVW};
         CMD_UV_FAULT: return {1'b1, LIM_UVF};
         default:      return 4'h0;
      endcase
   endfunction : lim_sel

   sense_resistance_scaler u_scaler (
      .clk         (MCLK),
      .rst_n       (RESETN),
      .gain_word   (r_reg.gain),
      .tempco_word (r_reg.tempco),
      .die_temp_c  (DIE_TEMP_C),
      .r_q16       (r_q16)
   );

   // sense uV << 16 over mohm Q16 gives mA
   restoring_divider u_div (
      .clk   (MCLK),
      .rst_n (RESETN),
      .start (r_reg.div_start),
      .num   ({r_reg.sense_mag, 16'h0000}),
      .den   (r_q16),
      .busy  (div_busy),
      .done  (div_done),
      .quot  (quot)
   );

   assign report = {r_reg.snap_t, r_reg.snap_e};

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      r_next = r_reg;
      r_next.rd_valid  = 1'b0;
      r_next.div_start = 1'b0;
      vin_q   = l11_q16(VIN_WORD);
      mv_full = (58'(vin_q) * 58'(MV_PER_V)) >>> 16;
      ms_tick = r_reg.ms_cnt == 17'(MS_CYCLES - 1);
      // clearing mid-update would leave a half-applied product behind
      clear_now = r_reg.clr_pend && !ADC_BUSY && !div_busy;

      if (VIN_VALID) begin // all six thresholds on every conversion
         r_next.status[ST_OV_FAULT] = vin_q > l11_q16(r_reg.lim[LIM_OVF]);
         r_next.status[ST_OV_WARN]  = vin_q > l11_q16(r_reg.lim[LIM_OVW]);
         r_next.status[ST_UV_WARN]  = vin_q < l11_q16(r_reg.lim[LIM_UVW]);
         r_next.status[ST_UV_FAULT] = vin_q < l11_q16(r_reg.lim[LIM_UVF]);
         if (vin_q > l11_q16(r_reg.lim[LIM_ON])) r_next.vin_good = 1'b1;
         else if (vin_q < l11_q16(r_reg.lim[LIM_OFF])) r_next.vin_good = 1'b0;
         if (mv_full < 58'sd0) r_next.vin_mv = 16'h0000;
         else if (mv_full > 58'sd65535) r_next.vin_mv = 16'hFFFF;
         else r_next.vin_mv = mv_full[15:0];
      end

      // ****************************************************
      // output enables
      // ****************************************************
      if (r_reg.vin_good) begin
         r_next.en = CHAN_REQ;
         r_next.toff_run = 1'b0;
      end else if (r_reg.toff_run) begin
         r_next.en = r_reg.en & CHAN_REQ;
         if (ms_tick) begin
            if (r_reg.toff_cnt == 16'h0000) begin
               r_next.en = 2'b00;
               r_next.toff_run = 1'b0;
            end else begin
               r_next.toff_cnt = r_reg.toff_cnt - 16'h0001;
            end
         end
      end else begin
         r_next.en = 2'b00;
      end
      if (r_reg.vin_good && !r_next.vin_good) begin
         if (TRACK_ENABLE && TOFF_DELAY_MS != 16'h0000) begin
            r_next.toff_run = 1'b1;
            r_next.toff_cnt = TOFF_DELAY_MS - 16'h0001;
         end else begin
            r_next.en = 2'b00;
         end
      end

      // ****************************************************
      // input current
      // ****************************************************
      if (IIN_VALID && !div_busy && !r_reg.div_start) begin
         r_next.div_start = 1'b1;
         r_next.sense_neg = IIN_SENSE_UV[15];
         r_next.sense_mag = IIN_SENSE_UV[15] ? 16'(-IIN_SENSE_UV) : IIN_SENSE_UV;
      end
      if (div_done) begin
         r_next.iin_ma  = (quot > 32'h0000FFFF) ? 16'hFFFF : quot[15:0];
         r_next.iin_neg = r_reg.sense_neg;
      end

      // ****************************************************
      // energy and time
      // ****************************************************
      p_uw = 32'(r_reg.vin_mv) * 32'(r_reg.iin_ma); // latest V times I
      x    = 33'(r_reg.res) + 33'(p_uw);
      qp   = 46'(x) * 46'(NJ_RECIP);
      q    = qp[45:32];
      rem  = x - 33'(q) * 33'(NJ_PER_MJ);
      // the reciprocal is low by at most two, so two corrections suffice
      for (int k = 0; k < 2; k++) begin
         if (rem >= 33'(NJ_PER_MJ)) begin
            rem = rem - 33'(NJ_PER_MJ);
            q   = q + 14'h0001;
         end
      end
      dec_now = r_reg.iin_neg && (r_reg.en == 2'b00);

      r_next.ms_cnt = ms_tick ? 17'h00000 : r_reg.ms_cnt + 17'h00001;
      if (clear_now) begin
         r_next.energy   = '0;
         r_next.time_ms  = '0;
         r_next.res      = 20'h00000;
         r_next.ms_cnt   = 17'h00000;
         r_next.clr_pend = 1'b0;
      end else if (ms_tick) begin // one count per ms, runs while frozen
         r_next.time_ms = r_reg.time_ms + 48'h1;
         if (dec_now) begin // never below zero
            r_next.energy = (r_reg.energy > 48'(q)) ? r_reg.energy - 48'(q) : '0;
         end else if (!r_reg.iin_neg) begin
            r_next.energy = r_reg.energy + 48'(q); // mJ, wraps
            r_next.res    = rem[19:0];
         end
      end

      // both halves from the same register instant
      if (!r_reg.frozen) begin
         r_next.snap_e = r_reg.energy;
         r_next.snap_t = r_reg.time_ms;
      end

      // ****************************************************
      // host commands
      // ****************************************************
      sel = lim_sel(CMD_CODE);
      if (CMD_WR) begin
         if (sel[3]) r_next.lim[sel[2:0]] = CMD_WDATA;
         case (CMD_CODE)
            CMD_GAIN:   r_next.gain   = CMD_WDATA;
            CMD_TEMPCO: r_next.tempco = CMD_WDATA;
            CMD_CONFIG: begin
               r_next.high_def = CMD_WDATA[CFG_HIGH_DEF_BIT];
               r_next.clr_pend = 1'b1;
            end
            default: ;
         endcase
      end
      if (CMD_SEND && CMD_CODE == CMD_CLEAR) r_next.clr_pend = 1'b1;
      if (BLK_DONE) r_next.frozen = 1'b0;
      if (CMD_RD) begin
         r_next.rd_valid = 1'b1;
         if (sel[3]) r_next.rd_data = r_reg.lim[sel[2:0]];
         else begin
            case (CMD_CODE)
               CMD_GAIN:   r_next.rd_data = r_reg.gain; // unlimited value
               CMD_TEMPCO: r_next.rd_data = r_reg.tempco;
               CMD_CONFIG: r_next.rd_data = 16'(r_reg.high_def) << CFG_HIGH_DEF_BIT;
               CMD_REPORT: begin
                  r_next.rd_data = {12'h000, REPORT_BYTES};
                  r_next.frozen  = 1'b1;
               end
               default:    r_next.rd_data = 16'h0000;
            endcase
         end
      end
      if (BYTE_RD) begin
         r_next.rd_valid = 1'b1;
         r_next.rd_data  = (BYTE_INDEX < REPORT_BYTES)
                         ? {8'h00, report[BYTE_INDEX*8 +: 8]} : 16'h0000;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         r_reg        <= '0;
         r_reg.lim    <= LIM_RESET;
         r_reg.gain   <= GAIN_RESET;
         r_reg.tempco <= TEMPCO_RESET;
         r_reg.high_def <= HIGH_DEF_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_pin
      assign OUTPUT_ENABLE_PIN[c] = r_reg.en[c];
   end
   assign RD_DATA            = r_reg.rd_data;
   assign RD_VALID           = r_reg.rd_valid;
   assign CONVERSION_ALLOWED = r_reg.vin_good;
   assign VIN_STATUS         = r_reg.status;
   assign HIGH_DEFINITION    = r_reg.high_def; // sequencer interleave request

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   sequence s_gain_write;
      CMD_WR && CMD_CODE == CMD_GAIN && !CMD_RD && !BYTE_RD;
   endsequence
   sequence s_gain_read;
      CMD_RD && !CMD_WR && CMD_CODE == CMD_GAIN && !BYTE_RD;
   endsequence

   AST_CONV_ON: assert property (VIN_VALID && vin_q > l11_q16(r_reg.lim[LIM_ON])
      |=> CONVERSION_ALLOWED) else $error("conversion not allowed above on level");
   AST_CONV_OFF: assert property (VIN_VALID && CONVERSION_ALLOWED && !TRACK_ENABLE
      && vin_q < l11_q16(r_reg.lim[LIM_OFF]) |=> OUTPUT_ENABLE_PIN == 2'b00)
      else $error("enables stayed on below off level");
   AST_OV_FAULT: assert property (VIN_VALID && vin_q > l11_q16(r_reg.lim[LIM_OVF])
      |=> VIN_STATUS[ST_OV_FAULT]) else $error("overvoltage fault missed");
   AST_UV_FAULT: assert property (VIN_VALID && vin_q >= l11_q16(r_reg.lim[LIM_UVF])
      |=> !VIN_STATUS[ST_UV_FAULT]) else $error("false undervoltage fault");
   AST_TIME_TICK: assert property (ms_tick && !clear_now
      |=> r_reg.time_ms == $past(r_reg.time_ms) + 48'h1) else $error("time missed a tick");
   AST_CLEAR: assert property (clear_now |=> r_reg.time_ms == '0 && r_reg.energy == '0
      && !r_reg.clr_pend) else $error("clear not applied");
   AST_FREEZE: assert property (r_reg.frozen && !BLK_DONE |=> $stable(r_reg.snap_e)
      && $stable(r_reg.snap_t)) else $error("snapshot moved during block read");
   AST_COHERENT: assert property (!r_reg.frozen |=> r_reg.snap_t == $past(r_reg.time_ms)
      && r_reg.snap_e == $past(r_reg.energy)) else $error("snapshot halves differ in age");
   AST_NO_NEG: assert property (ms_tick && !clear_now && dec_now
      && r_reg.energy <= 48'(q) |=> r_reg.energy == '0) else $error("energy underflow");
   AST_BYTE6: assert property (BYTE_RD && BYTE_INDEX == 4'h6 |=> RD_VALID
      && RD_DATA == {8'h00, $past(r_reg.snap_t[7:0])}) else $error("byte 6 not time lsb");
   AST_HIGH_DEF: assert property (CMD_WR && CMD_CODE == CMD_CONFIG
      |=> HIGH_DEFINITION == $past(CMD_WDATA[CFG_HIGH_DEF_BIT]))
      else $error("high definition bit not stored");
   AST_GAIN_BACK: assert property (s_gain_write ##2 s_gain_read
      |=> RD_DATA == $past(CMD_WDATA, 3)) else $error("gain readback differs");
endmodule : input_energy_supervisor
`default_nettype wire

/* File: host_model.sv */
// Purpose: host side of the decoded command port
// Assumes: strobes change only after the falling edge of mclk
// Notes:   reads queue their answer; bit 16 set means compare, else capture
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic                  mclk,
   output var  logic [4:0]            stb,
   output var  supervisor_pkg::code_t code,
   output var  supervisor_pkg::word_t wdata,
   output var  logic [3:0]            bidx
);
   import supervisor_pkg::*;
   logic [16:0] exp_q[$];
   initial begin
      stb = '0;
      code = '0;
      wdata = '0;
      bidx = '0;
   end
   // ****************
   // one strobe cycle: 0 write, 1 send, 2 read, 3 byte, 4 done
   // ****************
   task automatic go(input int k, input code_t c, input word_t d, input logic [3:0] i,
                     input logic [16:0] e);
      if (k == 2 || k == 3) exp_q.push_back(e);
      @(negedge mclk);
      code = c;
      wdata = d;
      bidx = i;
      stb = 5'(1 << k);
      @(negedge mclk);
      stb = '0;
      // scrambled once dropped, so a stale qualifier cannot pass
      code = ~c;
      wdata = ~d;
   endtask : go
endmodule : host_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the input energy supervisor
// Assumes: ms tick shortened to 20 clocks; gain 1 mohm, tempco 0
// Notes:   12 V at 10 A gives exactly 120 mJ per ms
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import supervisor_pkg::*;
   localparam int MSC = 20;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic [4:0]  stb;
   code_t       code;
   word_t       wdata, rd_data, last_rd, w;
   word_t       vin_word = 16'h000C;
   logic [3:0]  bidx, vin_status;
   logic        rd_valid, conv_ok, high_def;
   logic        vin_valid = 1'b0, adc_busy = 1'b0, track = 1'b0;
   logic [1:0]  chan_req = 2'b10, oe;
   logic [15:0] toff = 16'h0008;
   logic signed [15:0] sense = 16'sd10000;
   logic [16:0] note;
   logic [31:0] seed = 32'hF607;
   int          n_mismatch = 0, num_checks = 0;
   acc_t        e1, t1, e2, t2;
   code_t codes[9] = '{CMD_TURN_ON, CMD_TURN_OFF, CMD_OV_FAULT, CMD_OV_WARN, CMD_UV_WARN,
      CMD_UV_FAULT, CMD_GAIN, CMD_TEMPCO, CMD_CONFIG};
   word_t rst_v[9] = '{16'hD280, 16'hD240, 16'hD3C0, 16'hD380, 16'h8000, 16'h8000,
      16'hBA00, 16'h0000, 16'h0000};
   word_t use_v[8] = '{16'h000A, 16'h0009, 16'h000F, 16'h000E, 16'h0005, 16'h0004,
      16'hBA00, 16'h0000};
   // packed as {vin word, allowed, status}: hysteresis edges at 9 and 10
   logic [20:0] vt[7] = '{21'h00190, 21'h00213, 21'h001B0, 21'h00130, 21'h0006C,
      21'h00140, 21'h00190};
   input_energy_supervisor #(.MS_CYCLES(MSC)) dut_u (
      .MCLK(mclk), .RESETN(resetn), .CMD_WR(stb[0]), .CMD_SEND(stb[1]), .CMD_RD(stb[2]),
      .CMD_CODE(code), .CMD_WDATA(wdata), .BYTE_RD(stb[3]), .BYTE_INDEX(bidx),
      .BLK_DONE(stb[4]), .RD_DATA(rd_data), .RD_VALID(rd_valid), .VIN_VALID(vin_valid),
      .VIN_WORD(vin_word), .IIN_VALID(vin_valid), .IIN_SENSE_UV(sense),
      .DIE_TEMP_C(16'sd25), .ADC_BUSY(adc_busy), .CHAN_REQ(chan_req),
      .TRACK_ENABLE(track), .TOFF_DELAY_MS(toff), .OUTPUT_ENABLE_PIN(oe),
      .CONVERSION_ALLOWED(conv_ok), .VIN_STATUS(vin_status), .HIGH_DEFINITION(high_def));
   host_model host_u (.mclk(mclk), .stb(stb), .code(code), .wdata(wdata), .bidx(bidx));
   // ****************
   // clock, conversions, watcher
   // ****************
   always #5 mclk = ~mclk;
   always begin
      repeat (40) @(negedge mclk);
      vin_valid = 1'b1;
      @(negedge mclk);
      vin_valid = 1'b0;
   end
   always @(posedge mclk) begin
      if (rd_valid === 1'b1) begin
         last_rd = rd_data;
         note = (host_u.exp_q.size() > 0) ? host_u.exp_q.pop_front() : 17'h1FFFF;
         if (note[16]) check(rd_data, note[15:0]);
      end
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      if (host_u.exp_q.size() != 0) n_mismatch++;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic blk(output acc_t e, output acc_t t);
      host_u.go(2, CMD_REPORT, '0, '0, 17'h1000C);
      for (int i = 0; i < 12; i++) begin
         host_u.go(3, '0, '0, 4'(i), '0);
         @(posedge mclk);
         #1;
         if (i < 6) e[8*i +: 8] = last_rd[7:0];
         else t[8*i-48 +: 8] = last_rd[7:0];
      end
   endtask : blk
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (6) @(negedge mclk);
      resetn = 1'b1;
      for (int i = 0; i < 9; i++) host_u.go(2, codes[i], '0, '0, {1'b1, rst_v[i]});
      host_u.go(2, 8'h99, '0, '0, 17'h10000);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         w = 16'(xs());
         host_u.go(0, codes[i], w, '0, '0);
         host_u.go(2, codes[i], '0, '0, {1'b1, w});
         host_u.go(0, codes[i], use_v[i], '0, '0);
      end
      host_u.go(0, CMD_REPORT, 16'h1234, '0, '0);
      host_u.go(0, CMD_CONFIG, 16'h00FF, '0, '0);
      host_u.go(2, CMD_CONFIG, '0, '0, 17'h10004);
      check(high_def, 1'b1);
      host_u.go(0, CMD_CONFIG, 16'h0000, '0, '0);
      $display("test registers done");
      for (int i = 0; i < 7; i++) begin
         vin_word = vt[i][20:5];
         repeat (50) @(negedge mclk);
         check(conv_ok, vt[i][4]);
         check(vin_status, vt[i][3:0]);
         check(oe, vt[i][4] ? chan_req : 2'b00);
      end
      track = 1'b1;
      vin_word = 16'h0003;
      repeat (50) @(negedge mclk);
      check(oe, chan_req);
      repeat (200) @(negedge mclk);
      check(oe, 2'b00);
      vin_word = 16'h000C;
      track = 1'b0;
      $display("test thresholds done");
      repeat (100) @(negedge mclk);
      host_u.go(1, CMD_CLEAR, '0, '0, '0);
      // the clear may sit out one running divide, up to 32 cycles
      repeat (10 * MSC + 20) @(negedge mclk);
      blk(e1, t1);
      check(t1 >= 48'd9 && t1 <= 48'd11, 1'b1);
      check(e1, 48'd120 * t1);
      repeat (5 * MSC) @(negedge mclk);
      host_u.go(3, '0, '0, 4'h6, {9'h100, t1[7:0]});
      host_u.go(4, '0, '0, '0, '0);
      blk(e2, t2);
      check(t2 >= t1 + 48'd5, 1'b1);
      check(e2, 48'd120 * t2);
      host_u.go(4, '0, '0, '0, '0);
      $display("test energy report done");
      adc_busy = 1'b1;
      host_u.go(0, CMD_CONFIG, 16'h0004, '0, '0);
      repeat (3 * MSC) @(negedge mclk);
      blk(e1, t1);
      check(t1 >= t2 + 48'd3, 1'b1);
      check(high_def, 1'b1);
      host_u.go(4, '0, '0, '0, '0);
      adc_busy = 1'b0;
      repeat (2 * MSC) @(negedge mclk);
      blk(e1, t1);
      check(t1 <= 48'd3, 1'b1);
      check(e1, 48'd120 * t1);
      host_u.go(4, '0, '0, '0, '0);
      $display("test deferred clear done");
      chan_req = 2'b00;
      sense = -16'sd10000;
      repeat (15 * MSC) @(negedge mclk);
      blk(e1, t1);
      check(e1, 48'd0);
      host_u.go(4, '0, '0, '0, '0);
      $display("test energy decrement done");
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
